// [src/lcdid_map.svh]
`ifndef LCDID_MAP_SVH
`define LCDID_MAP_SVH

// ***************************************************************
// register offsets (byte addresses on the bus)
// ***************************************************************
`define LCDID_OFS_INSTR 8'h00
`define LCDID_OFS_ACCESS 8'h04
`define LCDID_OFS_STATUS 8'h08
`define LCDID_OFS_MODE 8'h0C
`define LCDID_OFS_POWER 8'h10

// ***************************************************************
// field positions and codes
// ***************************************************************
`define LCDID_HSIZE_WORD 3'h2
`define LCDID_ACCESS_WRITE_BIT 0
`define LCDID_SPACE_CODE 8'h20
`define LCDID_AC_HOME 7'h00
`define LCDID_LINE1_LAST 7'h27
`define LCDID_LINE2_FIRST 7'h40
`define LCDID_LINE2_LAST 7'h67
`define LCDID_ONE_LINE_LAST 7'h4F
`define LCDID_SHIFT_LAST_TWO 7'h27
`define LCDID_SHIFT_LAST_ONE 7'h4F

// ***************************************************************
// reset values
// ***************************************************************
`define LCDID_RST_OSC_TRIM 3'h4
`define LCDID_RST_CONTRAST 6'h20
`define LCDID_RST_GAIN 3'h2

// ***************************************************************
// timing
// ***************************************************************
`define LCDID_CLK_PERIOD_NS 5
`define LCDID_BLINK_HALF_NS 400000000
`define LCDID_BLINK_HALF_CYCLES (`LCDID_BLINK_HALF_NS / `LCDID_CLK_PERIOD_NS)

`endif

// [src/lcdid_pkg.sv]
package lcdid_pkg;
   timeunit 1ns;
   timeprecision 100ps;

   typedef enum logic [1:0] {
      LCDID_SP_DISP = 2'b00,
      LCDID_SP_GLYPH = 2'b01,
      LCDID_SP_SYM = 2'b10
   } lcdid_space_t;

   typedef struct packed {
      logic bus_width_select;
      logic two_line;
      logic double_height;
      logic table_select;
      logic display_on;
      logic cursor_on;
      logic blink_on;
      logic entry_up;
      logic entry_shift;
   } lcdid_mode_t;

   typedef struct packed {
      logic bias_select;
      logic [2:0] osc_trim;
      logic symbol_on;
      logic booster_on;
      logic follower_on;
      logic [2:0] follower_gain;
      logic [5:0] contrast_level;
   } lcdid_power_t;

   typedef struct packed {
      logic [1:0] font_sync;
      logic bus_sel;
      logic [7:0] bus_addr;
      logic bus_write;
      logic [31:0] rdata;
      logic nib_pend;
      logic [3:0] nib_hi;
      logic filling;
      logic [6:0] fill_addr;
      logic [6:0] address_counter;
      logic [6:0] display_shift;
      lcdid_space_t space;
      lcdid_mode_t mode;
      lcdid_power_t power;
      logic [26:0] blink_cnt;
      logic blink_phase;
   } lcdid_state_t;

endpackage

// [src/lcdid_decoder.sv]
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`include "lcdid_map.svh"

module lcdid_decoder #(
   parameter int unsigned BLINK_HALF_CYCLES = `LCDID_BLINK_HALF_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // font height option pin
   input wire logic font_height_pin,
   // display ram fill port
   output logic ram_we,
   output logic [6:0] ram_addr,
   output logic [7:0] ram_wdata,
   // panel controls
   output logic display_on,
   output logic cursor_on,
   output logic cursor_all_dots,
   output logic two_line,
   output logic font_5x16,
   output logic [6:0] address_counter,
   output logic [6:0] display_shift,
   output logic busy,
   // analog settings
   output lcdid_pkg::lcdid_power_t power
);
   timeunit 1ns;
   timeprecision 100ps;

   // ***************************************************************
   // address stepping
   // ***************************************************************
   function automatic logic [6:0] lcdid_ac_step(
      input logic [6:0] ac,
      input logic up,
      input lcdid_pkg::lcdid_space_t sp,
      input logic two,
      input logic dh
   );
      logic [6:0] last;
      logic [5:0] g;
      logic [3:0] s;
      last = dh ? `LCDID_LINE1_LAST : `LCDID_ONE_LINE_LAST;
      g = up ? ac[5:0] + 6'h01 : ac[5:0] - 6'h01;
      s = up ? ac[3:0] + 4'h1 : ac[3:0] - 4'h1;
      case (sp)
         lcdid_pkg::LCDID_SP_GLYPH: begin
            lcdid_ac_step = {1'b0, g};
         end
         lcdid_pkg::LCDID_SP_SYM: begin
            lcdid_ac_step = {3'h0, s};
         end
         default: begin
            if (two) begin
               // second line starts at a fixed offset, not right after the first
               if (up) begin
                  if (ac == `LCDID_LINE1_LAST) begin
                     lcdid_ac_step = `LCDID_LINE2_FIRST;
                  end else if (ac == `LCDID_LINE2_LAST) begin
                     lcdid_ac_step = `LCDID_AC_HOME;
                  end else begin
                     lcdid_ac_step = ac + 7'h01;
                  end
               end else begin
                  if (ac == `LCDID_LINE2_FIRST) begin
                     lcdid_ac_step = `LCDID_LINE1_LAST;
                  end else if (ac == `LCDID_AC_HOME) begin
                     lcdid_ac_step = `LCDID_LINE2_LAST;
                  end else begin
                     lcdid_ac_step = ac - 7'h01;
                  end
               end
            end else if (up) begin
               lcdid_ac_step = (ac >= last) ? `LCDID_AC_HOME : ac + 7'h01;
            end else begin
               lcdid_ac_step = (ac == `LCDID_AC_HOME) ? last : ac - 7'h01;
            end
         end
      endcase
   endfunction

   // shift position counts left moves; it wraps at the line length
   function automatic logic [6:0] lcdid_shift_step(
      input logic [6:0] sh,
      input logic left,
      input logic short_line
   );
      logic [6:0] last;
      last = short_line ? `LCDID_SHIFT_LAST_TWO : `LCDID_SHIFT_LAST_ONE;
      if (left) begin
         lcdid_shift_step = (sh >= last) ? 7'h00 : sh + 7'h01;
      end else begin
         lcdid_shift_step = (sh == 7'h00) ? last : sh - 7'h01;
      end
   endfunction

   // ***************************************************************
   // state
   // ***************************************************************
   lcdid_pkg::lcdid_state_t s_q;
   lcdid_pkg::lcdid_state_t s_d;

   logic font_pin_high;
   logic addr_ok;
   logic [31:0] rd_val;
   logic go;
   logic [7:0] ib;
   logic short_line;

   assign font_pin_high = s_q.font_sync[1];
   assign short_line = s_q.mode.two_line | s_q.mode.double_height;
   assign addr_ok = hsel & hready & htrans[1] & (hsize == `LCDID_HSIZE_WORD)
      & (haddr[31:8] == 24'h000000);

   // ***************************************************************
   // read mux
   // ***************************************************************
   always_comb begin
      rd_val = 32'h00000000;
      case (haddr[7:0])
         `LCDID_OFS_STATUS: begin
            rd_val = {9'h000, s_q.display_shift, 4'h0, s_q.space, s_q.nib_pend,
               s_q.filling, 1'b0, s_q.address_counter};
         end
         `LCDID_OFS_MODE: begin
            rd_val = {20'h00000, font_5x16, font_pin_high, s_q.mode, 1'b0};
         end
         `LCDID_OFS_POWER: begin
            rd_val = {10'h000, s_q.power.contrast_level, 5'h00,
               s_q.power.follower_gain, 1'b0, s_q.power.follower_on,
               s_q.power.booster_on, s_q.power.symbol_on, s_q.power.bias_select,
               s_q.power.osc_trim};
         end
         default: begin
            rd_val = 32'h00000000;
         end
      endcase
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      go = 1'b0;
      ib = 8'h00;
      s_d.font_sync = {s_q.font_sync[0], font_height_pin};

      // bus address phase; read data is sampled now and shown in the data phase
      s_d.bus_sel = addr_ok;
      if (addr_ok) begin
         s_d.bus_addr = haddr[7:0];
         s_d.bus_write = hwrite;
         s_d.rdata = hwrite ? 32'h00000000 : rd_val;
      end

      // clear fill walks the one-line locations 0x00 to 0x4F, one per cycle
      if (s_q.filling) begin
         s_d.fill_addr = s_q.fill_addr + 7'h01;
         if (s_q.fill_addr == `LCDID_ONE_LINE_LAST) begin
            s_d.filling = 1'b0;
            s_d.fill_addr = 7'h00;
         end
      end

      // writes arriving while busy are dropped; software polls status first
      if (s_q.bus_sel && s_q.bus_write && !s_q.filling) begin
         case (s_q.bus_addr)
            `LCDID_OFS_INSTR: begin
               if (s_q.mode.bus_width_select) begin
                  go = 1'b1;
                  ib = hwdata[7:0];
               end else if (!s_q.nib_pend) begin
                  s_d.nib_hi = hwdata[3:0];
                  s_d.nib_pend = 1'b1;
               end else begin
                  go = 1'b1;
                  ib = {s_q.nib_hi, hwdata[3:0]};
                  s_d.nib_pend = 1'b0;
               end
            end
            `LCDID_OFS_ACCESS: begin
               s_d.address_counter = lcdid_ac_step(s_q.address_counter,
                  s_q.mode.entry_up, s_q.space, s_q.mode.two_line,
                  s_q.mode.double_height);
               if (hwdata[`LCDID_ACCESS_WRITE_BIT] && s_q.mode.entry_shift
                     && s_q.space == lcdid_pkg::LCDID_SP_DISP) begin
                  s_d.display_shift = lcdid_shift_step(s_q.display_shift,
                     s_q.mode.entry_up, short_line);
               end
            end
            default: begin
            end
         endcase
      end

      // ***************************************************************
      // instruction execution
      // ***************************************************************
      if (go) begin
         casez (ib)
            8'b1???????: begin
               s_d.address_counter = ib[6:0];
               s_d.space = lcdid_pkg::LCDID_SP_DISP;
            end
            8'b01??????: begin
               if (!s_q.mode.table_select) begin
                  s_d.address_counter = {1'b0, ib[5:0]};
                  s_d.space = lcdid_pkg::LCDID_SP_GLYPH;
               end else begin
                  case (ib[5:4])
                     2'b00: begin
                        s_d.address_counter = {3'h0, ib[3:0]};
                        s_d.space = lcdid_pkg::LCDID_SP_SYM;
                     end
                     2'b01: begin
                        s_d.power.symbol_on = ib[3];
                        s_d.power.booster_on = ib[2];
                        s_d.power.contrast_level[5:4] = ib[1:0];
                     end
                     2'b10: begin
                        s_d.power.follower_on = ib[3];
                        s_d.power.follower_gain = ib[2:0];
                     end
                     default: begin
                        s_d.power.contrast_level[3:0] = ib[3:0];
                     end
                  endcase
               end
            end
            8'b001?????: begin
               // bit 1 is a test position the host keeps at zero; it is not decoded
               s_d.mode.bus_width_select = ib[4];
               s_d.mode.two_line = ib[3];
               s_d.mode.double_height = ib[2];
               s_d.mode.table_select = ib[0];
               s_d.nib_pend = 1'b0;
            end
            8'b0001????: begin
               if (s_q.mode.table_select) begin
                  s_d.power.bias_select = ib[3];
                  s_d.power.osc_trim = ib[2:0];
               end else if (!ib[3]) begin
                  s_d.address_counter = lcdid_ac_step(s_q.address_counter, ib[2],
                     s_q.space, s_q.mode.two_line, s_q.mode.double_height);
               end else begin
                  s_d.display_shift = lcdid_shift_step(s_q.display_shift, !ib[2],
                     short_line);
               end
            end
            8'b00001???: begin
               s_d.mode.display_on = ib[2];
               s_d.mode.cursor_on = ib[1];
               s_d.mode.blink_on = ib[0];
            end
            8'b000001??: begin
               s_d.mode.entry_up = ib[1];
               s_d.mode.entry_shift = ib[0];
            end
            8'b0000001?: begin
               s_d.address_counter = `LCDID_AC_HOME;
               s_d.display_shift = 7'h00;
               s_d.space = lcdid_pkg::LCDID_SP_DISP;
            end
            8'b00000001: begin
               s_d.filling = 1'b1;
               s_d.fill_addr = 7'h00;
               s_d.address_counter = `LCDID_AC_HOME;
               s_d.display_shift = 7'h00;
               s_d.mode.entry_up = 1'b1;
               s_d.space = lcdid_pkg::LCDID_SP_DISP;
            end
            default: begin
            end
         endcase
      end

      // blink timer only runs while blinking is on, so the phase starts fresh
      if (s_q.mode.blink_on) begin
         if (s_q.blink_cnt >= 27'(BLINK_HALF_CYCLES - 1)) begin
            s_d.blink_cnt = 27'h0000000;
            s_d.blink_phase = !s_q.blink_phase;
         end else begin
            s_d.blink_cnt = s_q.blink_cnt + 27'h0000001;
         end
      end else begin
         s_d.blink_cnt = 27'h0000000;
         s_d.blink_phase = 1'b0;
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '{
            filling: 1'b1, address_counter: `LCDID_AC_HOME,
            space: lcdid_pkg::LCDID_SP_DISP,
            mode: '{bus_width_select: 1'b1, entry_up: 1'b1, default: 1'b0},
            power: '{osc_trim: `LCDID_RST_OSC_TRIM, follower_gain: `LCDID_RST_GAIN,
               contrast_level: `LCDID_RST_CONTRAST, default: '0},
            default: '0
         };
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign ram_we = s_q.filling;
   assign ram_addr = s_q.fill_addr;
   assign ram_wdata = `LCDID_SPACE_CODE;
   assign display_on = s_q.mode.display_on;
   assign cursor_on = s_q.mode.cursor_on;
   assign cursor_all_dots = s_q.mode.blink_on & s_q.blink_phase;
   assign two_line = s_q.mode.two_line;
   // the pin forces the normal font; double height never pairs with two lines
   assign font_5x16 = s_q.mode.double_height & ~s_q.mode.two_line
      & ~font_pin_high;
   assign address_counter = s_q.address_counter;
   assign display_shift = s_q.display_shift;
   assign busy = s_q.filling;
   assign power = s_q.power;

endmodule

// [tb/lcdid_decoder_chk.sv]
module lcdid_decoder_chk #(
   parameter int unsigned BLINK_HALF_CYCLES = 8
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // pin and panel
   input wire logic font_height_pin,
   input wire logic ram_we,
   input wire logic [6:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   input wire logic display_on,
   input wire logic cursor_on,
   input wire logic cursor_all_dots,
   input wire logic two_line,
   input wire logic font_5x16,
   input wire logic [6:0] address_counter,
   input wire logic busy,
   input wire lcdid_pkg::lcdid_power_t power
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // helper counters
   // ****************************************
   logic instr_wr;
   logic [31:0] busy_cnt_q;
   logic [31:0] dots_cnt_q;
   assign instr_wr = hsel && hready && htrans[1] && hwrite && hsize == 3'h2 && haddr == 32'h0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_cnt_q <= 32'h0;
         dots_cnt_q <= 32'h0;
      end else begin
         busy_cnt_q <= busy ? busy_cnt_q + 32'h1 : 32'h0;
         dots_cnt_q <= cursor_all_dots ? dots_cnt_q + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // two-ff synchroniser: three sampled highs are enough to see the pin
   sequence pin_held;
      font_height_pin [*3];
   endsequence

   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_space_code: assert property (ram_we |-> ram_wdata == 8'h20) else $error("fill not space");
   a_fill_range: assert property (ram_we |-> ram_addr <= 7'h4F) else $error("fill out of range");
   a_fill_busy: assert property (ram_we |-> busy) else $error("fill while not busy");
   a_busy_len: assert property (busy_cnt_q <= 32'h50) else $error("busy too long");
   a_clear_home: assert property ($fell(busy) |-> address_counter == 7'h00) else $error("no home");
   a_font_lines: assert property (font_5x16 |-> !two_line) else $error("tall font two lines");
   a_pin_forces: assert property (pin_held |-> !font_5x16) else $error("pin ignored");
   a_blink_half: assert property (dots_cnt_q <= BLINK_HALF_CYCLES) else $error("blink half long");
   a_mode_cause: assert property ($changed({display_on, cursor_on, two_line}) |-> $past(instr_wr, 2))
      else $error("mode moved without instruction");
   a_power_cause: assert property ($changed(power) |-> $past(instr_wr, 2))
      else $error("power moved without instruction");
endmodule

bind lcdid_decoder lcdid_decoder_chk #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .font_height_pin(font_height_pin), .ram_we(ram_we), .ram_addr(ram_addr),
   .ram_wdata(ram_wdata), .display_on(display_on), .cursor_on(cursor_on),
   .cursor_all_dots(cursor_all_dots), .two_line(two_line), .font_5x16(font_5x16),
   .address_counter(address_counter), .busy(busy), .power(power)
);

// [tb/lcdid_host.sv]
`include "lcdid_map.svh"

module lcdid_host (
   // clock
   input wire logic hclk,
   // ahb-lite master
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // single word transfers
   // ****************************************
   logic nib4 = 1'b0;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      // stale data must not look valid once the data phase is over
      hwdata <= ~wd;
   endtask

   task automatic send_instr(input logic [7:0] b);
      logic [7:0] v;
      logic [31:0] rd;
      v = b;
      if (v[7:5] == 3'b001) begin
         v[1] = 1'b0;
         if (v[3]) v[2] = 1'b0;
      end
      if (nib4) begin
         xfer(1'b1, `LCDID_OFS_INSTR, {28'h0, v[7:4]}, rd);
         xfer(1'b1, `LCDID_OFS_INSTR, {28'h0, v[3:0]}, rd);
      end else begin
         xfer(1'b1, `LCDID_OFS_INSTR, {24'h0, v}, rd);
      end
      if (v[7:5] == 3'b001) nib4 = ~v[4];
   endtask
endmodule

// [tb/lcdid_decoder_bench.sv]
`include "lcdid_map.svh"

module lcdid_decoder_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // short blink so the phase can be counted in a few dozen cycles
   localparam int unsigned HALF = 8;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic font_height_pin = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, ram_we, display_on, cursor_on, cursor_all_dots;
   logic two_line, font_5x16, busy;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [6:0] ram_addr, address_counter, display_shift;
   logic [7:0] ram_wdata;
   lcdid_pkg::lcdid_power_t power, pw;
   int err_total = 0;
   int n_compared = 0;
   int n;
   always #2.5 hclk = ~hclk;

   lcdid_decoder #(.BLINK_HALF_CYCLES(HALF)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .font_height_pin(font_height_pin),
      .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .display_on(display_on),
      .cursor_on(cursor_on), .cursor_all_dots(cursor_all_dots), .two_line(two_line),
      .font_5x16(font_5x16), .address_counter(address_counter),
      .display_shift(display_shift), .busy(busy), .power(power));
   lcdid_host i_host (
      .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] st(input logic [6:0] ac, input logic [1:0] sp,
                                      input logic [6:0] sh);
      return {9'h0, sh, 4'h0, sp, 3'h0, ac};
   endfunction
   task automatic ins(input logic [7:0] b);
      i_host.send_instr(b);
      @(negedge hclk);
   endtask
   task automatic acc(input logic w);
      i_host.xfer(1'b1, `LCDID_OFS_ACCESS, {31'h0, w}, v);
      @(negedge hclk);
   endtask
   task automatic rd(input logic [7:0] a);
      i_host.xfer(1'b0, a, 32'h0, v);
   endtask
   task automatic count_fill();
      n = 0;
      do begin
         @(negedge hclk);
         if (ram_we === 1'b1 && ram_wdata === 8'h20 && ram_addr === n[6:0]) n++;
      end while (busy !== 1'b0 && n < 300);
   endtask
   task automatic count_dots();
      n = 0;
      repeat (48) begin
         @(negedge hclk);
         if (cursor_all_dots === 1'b1) n++;
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      count_fill();
      check(n, 80);
      rd(`LCDID_OFS_MODE);
      check(v, 32'h204);
      rd(`LCDID_OFS_POWER);
      check(v, 32'h0020_0204);
      rd(`LCDID_OFS_STATUS);
      check(v, st(7'h00, 2'h0, 7'h00));
      rd(8'h40);
      check(v, 32'h0);
   endtask
   task automatic t_entry();
      ins(8'h07);
      acc(1'b1);
      rd(`LCDID_OFS_STATUS);
      check(v, st(7'h01, 2'h0, 7'h01));
      acc(1'b0);
      rd(`LCDID_OFS_STATUS);
      check(v, st(7'h02, 2'h0, 7'h01));
      ins(8'h05);
      acc(1'b1);
      rd(`LCDID_OFS_STATUS);
      check(v, st(7'h01, 2'h0, 7'h00));
      ins(8'h04);
      acc(1'b1);
      ins(8'h06);
      ins(8'h7F);
      acc(1'b1);
      rd(`LCDID_OFS_STATUS);
      check(v, st(7'h00, 2'h1, 7'h00));
      ins(8'h04);
      acc(1'b0);
      rd(`LCDID_OFS_STATUS);
      check(v, st(7'h3F, 2'h1, 7'h00));
   endtask
   task automatic t_clear();
      i_host.send_instr(8'h01);
      count_fill();
      check(n, 80);
      rd(`LCDID_OFS_MODE);
      check(v[2], 1'b1);
      rd(`LCDID_OFS_STATUS);
      check(v, st(7'h00, 2'h0, 7'h00));
   endtask
   task automatic t_shift();
      ins(8'h38);
      check(two_line, 1'b1);
      ins(8'h10);
      check(address_counter, 7'h67);
      repeat (39) ins(8'h10);
      check(address_counter, 7'h40);
      ins(8'h10);
      check(address_counter, 7'h27);
      ins(8'h14);
      check(address_counter, 7'h40);
      ins(8'h18);
      check({display_shift, address_counter}, {7'h01, 7'h40});
      ins(8'h1C);
      ins(8'h1C);
      check({display_shift, address_counter}, {7'h27, 7'h40});
      ins(8'h02);
      check({display_shift, address_counter}, 14'h0);
   endtask
   task automatic t_display();
      ins(8'h0F);
      check({display_on, cursor_on}, 2'b11);
      count_dots();
      check(n, 24);
      ins(8'h0D);
      rd(`LCDID_OFS_MODE);
      check({cursor_on, v[2]}, 2'b01);
      ins(8'h08);
      count_dots();
      check({display_on, n[7:0]}, 9'h0);
   endtask
   task automatic t_font();
      ins(8'h34);
      check({font_5x16, two_line}, 2'b10);
      ins(8'hA7);
      ins(8'h14);
      check(address_counter, 7'h00);
      @(posedge hclk);
      font_height_pin <= 1'b1;
      repeat (4) @(negedge hclk);
      check(font_5x16, 1'b0);
      @(posedge hclk);
      font_height_pin <= 1'b0;
      repeat (4) @(negedge hclk);
      check(font_5x16, 1'b1);
      ins(8'h3C);
      check({font_5x16, two_line}, 2'b01);
   endtask
   task automatic t_ext();
      ins(8'h31);
      ins(8'h4A);
      ins(8'h1B);
      ins(8'h5E);
      ins(8'h6D);
      ins(8'h75);
      pw = '{bias_select: 1'b1, osc_trim: 3'h3, symbol_on: 1'b1, booster_on: 1'b1,
             follower_on: 1'b1, follower_gain: 3'h5, contrast_level: 6'h25};
      check(power, pw);
      rd(`LCDID_OFS_POWER);
      check(v, 32'h0025_057B);
      rd(`LCDID_OFS_STATUS);
      check(v, st(7'h0A, 2'h2, 7'h00));
      ins(8'h30);
   endtask
   task automatic t_nibble();
      ins(8'h20);
      i_host.xfer(1'b1, `LCDID_OFS_INSTR, 32'h0, v);
      rd(`LCDID_OFS_STATUS);
      check({v[9], display_on}, 2'b10);
      i_host.xfer(1'b1, `LCDID_OFS_INSTR, 32'hC, v);
      @(negedge hclk);
      check(display_on, 1'b1);
      ins(8'h30);
      rd(`LCDID_OFS_MODE);
      check(v[9], 1'b1);
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      t_reset();
      t_entry();
      t_clear();
      t_shift();
      t_display();
      t_font();
      t_ext();
      t_nibble();
      report_and_stop();
   end
   // the sequence needs well under a thousand cycles; this is far beyond it
   initial begin
      #200000;
      err_total++;
      report_and_stop();
   end
endmodule
